// ---- logic/lih_defines.svh ----
// Constants of the local interrupt handler: register offsets, reset values,
// source positions and timing. Assumes a 100 MHz clock.
`ifndef LIH_DEFINES_SVH
`define LIH_DEFINES_SVH

// ==============================================================
// Register map (byte addresses)
`define LIH_ADDR_W 8
`define LIH_OFS_PEND 8'h00
`define LIH_OFS_ENA 8'h04
`define LIH_OFS_SWSET 8'h08
`define LIH_OFS_VBASE 8'h0C
`define LIH_OFS_LVL0 8'h10
`define LIH_OFS_LVL1 8'h14
`define LIH_OFS_LVL2 8'h18
`define LIH_OFS_LVL3 8'h1C
`define LIH_OFS_CUR 8'h20
`define LIH_WORD_BYTES 4
`define LIH_VBASE_LSB 5

// ==============================================================
// Reset values
`define LIH_ENA_RST 31'h0
`define LIH_LVL_RST 3'h0
`define LIH_VBASE_RST 3'h2
`define LIH_SPUR_VEC 8'h18

// ==============================================================
// Source layout
`define LIH_NSRC 31
`define LIH_NHW_EDGE 16
`define LIH_NEDGE 24
`define LIH_SW_LO 16
`define LIH_IRQ_LO 24
`define LIH_LVL_PER_WORD 8
`define LIH_LVL_STRIDE 4

// ==============================================================
// Timing
`define LIH_CLK_NS 10
`define LIH_ACF_FILT_NS 1000
`define LIH_ACF_FILT_CYC ((`LIH_ACF_FILT_NS + `LIH_CLK_NS - 1) / `LIH_CLK_NS)

`endif

// ---- logic/lih_pkg.sv ----
// Types of the local interrupt handler.
// Assumes lih_defines.svh is on the include path.
`default_nettype none
`include "lih_defines.svh"

package lih_pkg;

   // ==============================================================
   // Hardware interrupt inputs
   typedef struct packed {
      logic acfail_n;
      logic abort;
      logic sysfail_n;
      logic wpost_err;
      logic ext_in;
      logic vme_ack;
      logic tick1;
      logic tick2;
      logic block_mover_done;
      logic [3:0] shared_signal_bits;
      logic [1:0] loc_mon;
      logic [7:1] vme_irq_n;
   } lih_src_t;

   // ==============================================================
   // Answer to a local acknowledge cycle
   typedef struct packed {
      logic done;
      logic spurious;
      logic [7:0] vector;
   } lih_iack_ans_t;

   // ==============================================================
   // Request to the backplane master for a remote acknowledge
   typedef struct packed {
      logic start;
      logic [2:0] level;
   } lih_vme_iack_t;

   typedef enum logic [1:0] {
      LIH_ST_IDLE = 2'b01,
      LIH_ST_VME = 2'b10
   } lih_state_t;

endpackage : lih_pkg

`default_nettype wire

// ---- logic/lih_edge_det.sv ----
// Rising-edge detector for a group of asserted-high event lines.
// Assumes inputs synchronous to i_clk.
`timescale 1ns/1ns
`default_nettype none

module lih_edge_det #(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Levels in, one-cycle pulses out
   input wire logic [WIDTH-1:0] i_level,
   output logic [WIDTH-1:0] o_rise
);

   logic [WIDTH-1:0] prev_reg;
   logic [WIDTH-1:0] prev_next;

   // ==============================================================
   // Edge compare per line
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_bit
         assign o_rise[g] = i_level[g] & ~prev_reg[g];
         assign prev_next[g] = i_level[g];
      end
   endgenerate

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         prev_reg <= '0;
      end
      else
      begin
         prev_reg <= prev_next;
      end
   end

endmodule : lih_edge_det

`default_nettype wire

// ---- logic/lih_top.sv ----
// Local interrupt handler: latches 24 edge and follows 7 level sources, maps each to a programmable
// local level, drives the encoded request level and answers acknowledges.
// Assumes a register master with one-cycle strobes and a backplane master
// that runs remote acknowledge cycles on request.
//
// Operation
// - 31 sources, each enableable onto any programmable local level.
// - Power-fail line filtered against bus-busy glitch, then edge detected.
// - System-failure line latches an interrupt on its edge.
// - Posted-write bus error latches an interrupt on its edge.
// - Edge IRQ1 source answered with own vector, no remote acknowledge.
// - Acknowledge of our own backplane request latches an edge interrupt.
// - Each tick timer pulse latches its own edge source.
// - Block mover completion latches an edge source.
// - Each of four shared signal bits latches its own edge source.
// - Each of two location-monitor bits latches its own edge source.
// - Eight software sources set directly by register writes.
// - Seven backplane request lines are level sources following the lines.
// - Local source acknowledge returns a vector unique to the source.
// - Edge requests stay pending through acknowledge; software clears them.
// - Backplane source acknowledge runs remote cycle and returns its vector.
// - Prioritised levels and acknowledge follow host request protocol.
`timescale 1ns/1ns
`default_nettype none

module lih_top
   import lih_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Register port
   input wire logic [`LIH_ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   // Interrupt sources
   input wire lih_src_t i_src,
   // Host request and acknowledge
   output logic [2:0] o_irq_level,
   input wire logic i_iack_req,
   input wire logic [2:0] i_iack_level,
   output lih_iack_ans_t o_iack,
   // Backplane acknowledge master
   output lih_vme_iack_t o_vme_iack,
   input wire logic i_vme_iack_done,
   input wire logic [7:0] i_vme_iack_vector
);

   localparam logic [6:0] ACF_FILT = 7'(`LIH_ACF_FILT_CYC);

   // ==============================================================
   // Find the lowest-numbered request at a given level
   function automatic logic [5:0] find_src(input logic [30:0] req,
                                           input logic [30:0][2:0] lv,
                                           input logic [2:0] want);
      logic [5:0] res;
      res = 6'h00;
      for (int i = `LIH_NSRC - 1; i >= 0; i--)
      begin
         if (req[i] && (lv[i] == want))
         begin
            res = {1'b1, 5'(i)};
         end
      end
      return res;
   endfunction : find_src

   // ==============================================================
   // Power-fail glitch filter
   logic [6:0] acf_cnt_reg;
   logic [6:0] acf_cnt_next;
   logic acf_ok;

   always_comb
   begin
      // Any high sample restarts the count, which then holds at the limit
      acf_cnt_next = i_src.acfail_n ? 7'h00 : acf_cnt_reg + 7'(!acf_ok);
   end

   // A short low pulse from the busy-line glitch never reaches the count
   assign acf_ok = (acf_cnt_reg == ACF_FILT);

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         acf_cnt_reg <= 7'h00;
      end
      else
      begin
         acf_cnt_reg <= acf_cnt_next;
      end
   end

   // ==============================================================
   // Edge sources
   logic [`LIH_NHW_EDGE-1:0] hw_level;
   logic [`LIH_NHW_EDGE-1:0] hw_rise;

   assign hw_level = {i_src.loc_mon,
                      i_src.shared_signal_bits,
                      i_src.block_mover_done,
                      i_src.tick2,
                      i_src.tick1,
                      i_src.vme_ack,
                      ~i_src.vme_irq_n[1],
                      i_src.ext_in,
                      i_src.wpost_err,
                      ~i_src.sysfail_n,
                      i_src.abort,
                      acf_ok};

   lih_edge_det #(
      .WIDTH(`LIH_NHW_EDGE)
   ) u_edge (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_level(hw_level),
      .o_rise(hw_rise)
   );

   // ==============================================================
   // Register file
   logic [`LIH_NEDGE-1:0] pend_reg;
   logic [`LIH_NEDGE-1:0] pend_next;
   logic [30:0] ena_reg;
   logic [30:0] ena_next;
   logic [30:0][2:0] lvl_reg;
   logic [30:0][2:0] lvl_next;
   logic [2:0] vbase_reg;
   logic [2:0] vbase_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [30:0] status;
   logic [30:0] req;
   logic [2:0] cur_lvl;
   logic [4:0] cur_idx;
   // Level sources are not latched: they follow the lines
   assign status = {~i_src.vme_irq_n, pend_reg};
   assign req = status & ena_reg;

   always_comb
   begin
      logic [`LIH_NEDGE-1:0] clr;
      logic [`LIH_NEDGE-1:0] set;
      logic [`LIH_ADDR_W-1:0] lofs;
      clr = '0;
      set = {8'h00, hw_rise};
      lofs = '0;
      ena_next = ena_reg;
      lvl_next = lvl_reg;
      vbase_next = vbase_reg;
      if (i_wr)
      begin
         // Acknowledge never clears; only a write to the pending word does
         unique case (i_addr)
            `LIH_OFS_PEND: clr = i_wdata[`LIH_NEDGE-1:0];
            `LIH_OFS_SWSET: set[`LIH_NEDGE-1:`LIH_SW_LO] = i_wdata[7:0];
            `LIH_OFS_ENA: ena_next = i_wdata[30:0];
            `LIH_OFS_VBASE: vbase_next = i_wdata[`LIH_VBASE_LSB +: 3];
            default: clr = '0;
         endcase
      end
      for (int i = 0; i < `LIH_NSRC; i++)
      begin
         lofs = `LIH_OFS_LVL0 + `LIH_ADDR_W'((i / `LIH_LVL_PER_WORD) * `LIH_WORD_BYTES);
         if (i_wr && (i_addr == lofs))
         begin
            lvl_next[i] = i_wdata[(i % `LIH_LVL_PER_WORD) * `LIH_LVL_STRIDE +: 3];
         end
      end
      // A new event in the clearing cycle survives
      pend_next = (pend_reg & ~clr) | set;
   end

   always_comb
   begin
      logic [`LIH_ADDR_W-1:0] lofs;
      lofs = '0;
      rdata_next = 32'h0000_0000;
      if (i_rd)
      begin
         unique case (i_addr)
            `LIH_OFS_PEND: rdata_next = {1'b0, status};
            `LIH_OFS_ENA: rdata_next = {1'b0, ena_reg};
            `LIH_OFS_VBASE: rdata_next = 32'(vbase_reg) << `LIH_VBASE_LSB;
            `LIH_OFS_CUR: rdata_next = {24'h000000, cur_idx, cur_lvl};
            default:
            begin
               for (int i = 0; i < `LIH_NSRC; i++)
               begin
                  lofs = `LIH_OFS_LVL0 + `LIH_ADDR_W'((i / `LIH_LVL_PER_WORD) * `LIH_WORD_BYTES);
                  if (i_addr == lofs)
                  begin
                     rdata_next[(i % `LIH_LVL_PER_WORD) * `LIH_LVL_STRIDE +: 3] = lvl_reg[i];
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         pend_reg <= '0;
         ena_reg <= `LIH_ENA_RST;
         lvl_reg <= {`LIH_NSRC{`LIH_LVL_RST}};
         vbase_reg <= `LIH_VBASE_RST;
         rdata_reg <= 32'h0000_0000;
      end
      else
      begin
         pend_reg <= pend_next;
         ena_reg <= ena_next;
         lvl_reg <= lvl_next;
         vbase_reg <= vbase_next;
         rdata_reg <= rdata_next;
      end
   end

   assign o_rdata = rdata_reg;

   // ==============================================================
   // Priority resolution
   logic [2:0] lvl_out_reg;
   always_comb
   begin
      logic [5:0] f;
      f = 6'h00;
      cur_lvl = 3'h0;
      cur_idx = 5'h00;
      // Level 0 means not routed, so it never requests
      for (int l = 1; l < 8; l++)
      begin
         f = find_src(req, lvl_reg, 3'(l));
         if (f[5])
         begin
            cur_lvl = 3'(l);
            cur_idx = f[4:0];
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         lvl_out_reg <= 3'h0;
      end
      else
      begin
         lvl_out_reg <= cur_lvl;
      end
   end

   assign o_irq_level = lvl_out_reg;

   // ==============================================================
   // Acknowledge sequencer
   lih_state_t state_reg;
   lih_state_t state_next;
   lih_iack_ans_t ans_reg;
   lih_iack_ans_t ans_next;
   lih_vme_iack_t vme_reg;
   lih_vme_iack_t vme_next;

   always_comb
   begin
      logic [5:0] f;
      f = find_src(req, lvl_reg, i_iack_level);
      state_next = state_reg;
      ans_next = '0;
      vme_next = '0;
      vme_next.level = vme_reg.level;
      unique case (state_reg)
         LIH_ST_IDLE:
         begin
            if (i_iack_req)
            begin
               if (!f[5])
               begin
                  ans_next.done = 1'b1;
                  ans_next.spurious = 1'b1;
                  ans_next.vector = `LIH_SPUR_VEC;
               end
               else if (f[4:0] >= 5'(`LIH_IRQ_LO))
               begin
                  vme_next.start = 1'b1;
                  vme_next.level = 3'(f[4:0] - 5'(`LIH_IRQ_LO - 1));
                  state_next = LIH_ST_VME;
               end
               else
               begin
                  // Includes the edge IRQ1 source: no remote cycle
                  ans_next.done = 1'b1;
                  ans_next.vector = {vbase_reg, f[4:0]};
               end
            end
         end
         LIH_ST_VME:
         begin
            if (i_vme_iack_done)
            begin
               ans_next.done = 1'b1;
               ans_next.vector = i_vme_iack_vector;
               state_next = LIH_ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_reg <= LIH_ST_IDLE;
         ans_reg <= '0;
         vme_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         ans_reg <= ans_next;
         vme_reg <= vme_next;
      end
   end
   assign o_iack = ans_reg;
   assign o_vme_iack = vme_reg;

endmodule : lih_top

`default_nettype wire

// ---- dv/lih_checker.sv ----
// Checker for the lih_top ports: read data, acknowledge answers.
// Assumes it is bound to lih_top and sees one clock domain.
`timescale 1ns/1ns
`default_nettype none

module lih_checker
   import lih_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Register port
   input wire logic i_rd,
   input wire logic [31:0] o_rdata,
   // Acknowledge
   input wire logic i_iack_req,
   input wire lih_iack_ans_t o_iack,
   input wire lih_vme_iack_t o_vme_iack,
   input wire logic i_vme_iack_done,
   input wire logic [7:0] i_vme_iack_vector
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   // ==============================================================
   // Acknowledge steps
   sequence s_taken;
      i_iack_req;
   endsequence
   sequence s_answer;
      o_iack.done || o_vme_iack.start;
   endsequence
   sequence s_remote;
      i_vme_iack_done ##1 (o_iack.done && o_iack.vector == $past(i_vme_iack_vector));
   endsequence

   // ==============================================================
   // Properties
   a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
      else $error("read data outside read cycle");
   a_ack_answer: assert property (s_taken |=> s_answer)
      else $error("acknowledge not answered next cycle");
   a_done_pulse: assert property (o_iack.done |=> !o_iack.done)
      else $error("done longer than one cycle");
   a_start_pulse: assert property (o_vme_iack.start |=> !o_vme_iack.start)
      else $error("remote start longer than one cycle");
   a_start_excl: assert property (o_vme_iack.start |-> !o_iack.done && o_vme_iack.level != 3'h0)
      else $error("remote start with done or level zero");
   a_wait_quiet: assert property (o_vme_iack.start |=> !o_iack.done until i_vme_iack_done)
      else $error("done before remote vector arrived");
   a_remote_vec: assert property (i_vme_iack_done |-> s_remote)
      else $error("remote vector not returned");
   a_spur_vec: assert property (o_iack.done && o_iack.spurious |-> o_iack.vector == 8'h18)
      else $error("wrong spurious vector");
endmodule : lih_checker

`default_nettype wire

// ---- dv/lih_vme_master_model.sv ----
// Backplane master model: runs a remote acknowledge and returns a vector.
// Assumes start is a one-cycle pulse; answers promptly and slowly in turn.
`timescale 1ns/1ns
`default_nettype none

module lih_vme_master_model
   import lih_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Request and answer
   input wire lih_vme_iack_t i_req,
   output logic o_done,
   output logic [7:0] o_vector
);
   logic busy;
   logic slow;
   logic [3:0] cnt;

   // Vector lines show the inverse once released, so stale data never matches
   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         busy <= 1'b0;
         slow <= 1'b0;
         cnt <= 4'h0;
         o_done <= 1'b0;
         o_vector <= 8'h00;
      end
      else
      begin
         o_done <= 1'b0;
         if (o_done)
            o_vector <= ~o_vector;
         if (i_req.start)
         begin
            busy <= 1'b1;
            cnt <= slow ? 4'h7 : 4'h0;
            slow <= ~slow;
         end
         else if (busy && cnt == 4'h0)
         begin
            busy <= 1'b0;
            o_done <= 1'b1;
            o_vector <= {5'h15, i_req.level};
         end
         else if (busy)
            cnt <= cnt - 4'h1;
      end
   end
endmodule : lih_vme_master_model

`default_nettype wire

// ---- dv/tb_lih_top.sv ----
// Self-checking bench for lih_top: sources, levels, acknowledges.
// Assumes lih_pkg compiled first; the backplane master is modelled.
`timescale 1ns/1ns
`default_nettype none

module tb_lih_top;
   import lih_pkg::*;
   localparam int POS [16] = '{21, 20, 19, 18, 17, 0, 16, 15, 14, 13, 9, 10, 11, 12, 7, 8};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_prev = 1'b0;
   logic [21:0] src_bits = 22'h28007F;
   logic iack_req = 1'b0;
   logic [2:0] iack_lvl = 3'h0;
   logic [2:0] lvl;
   logic [31:0] rdata;
   logic [2:0] irq_level;
   lih_iack_ans_t iack;
   lih_vme_iack_t vme;
   logic vdone;
   logic [7:0] vvec;
   logic [31:0] rd_q [$];
   logic [8:0] ack_q [$];
   int failures = 0;
   int samples_checked = 0;
   int seed = 62254;
   int idx;
   int n;

   lih_top dut (.i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
      .i_rd(rd), .o_rdata(rdata), .i_src(lih_src_t'(src_bits)), .o_irq_level(irq_level),
      .i_iack_req(iack_req), .i_iack_level(iack_lvl), .o_iack(iack), .o_vme_iack(vme),
      .i_vme_iack_done(vdone), .i_vme_iack_vector(vvec));
   lih_vme_master_model u_vme (.i_clk(clk), .i_rst(rst), .i_req(vme), .o_done(vdone),
      .o_vector(vvec));

   initial
   begin
      forever #5 clk = ~clk;
   end

   // ==============================================================
   // Tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run();
      $display("checked=%0d failures=%0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : complete_run

   task automatic wr_t(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_t

   task automatic rd_t(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      rd_q.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
   endtask : rd_t

   task automatic ack(input logic [2:0] l, input logic [8:0] e);
      @(posedge clk);
      iack_req <= 1'b1;
      iack_lvl <= l;
      ack_q.push_back(e);
      @(posedge clk);
      iack_req <= 1'b0;
      repeat (40) @(negedge clk) if (iack.done === 1'b1) break;
   endtask : ack

   task automatic flip(input int p);
      @(posedge clk);
      src_bits <= src_bits ^ (22'h1 << p);
   endtask : flip

   // ==============================================================
   // Output monitor: oldest note against what appears
   always @(negedge clk)
   begin
      if (rd_prev)
         check(rdata, rd_q.pop_front());
      if (iack.done === 1'b1)
         check({iack.spurious, iack.vector}, ack_q.pop_front());
      rd_prev = rd;
   end

   initial
   begin
      #200000;
      failures++;
      complete_run();
   end

   // ==============================================================
   // Scenarios
   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rd_t(8'h04, 32'h0);
      rd_t(8'h0C, 32'h40);
      rd_t(8'h30, 32'h0);
      ack(3'h3, 9'h118);
      for (idx = 1; idx < 31; idx++)
      begin
         lvl = 3'(1 + $unsigned($random(seed)) % 7);
         wr_t(8'h10 + 8'(idx / 8 * 4), 32'(lvl) << (idx % 8 * 4));
         wr_t(8'h04, 32'h1 << idx); // never edge and level IRQ1 together
         if (idx >= 16 && idx < 24)
            wr_t(8'h08, 32'h1 << (idx - 16));
         else
            flip(idx < 16 ? POS[idx] : idx - 24);
         if (idx < 16)
            flip(POS[idx]);
         repeat (3) @(posedge clk);
         check(irq_level, 32'(lvl));
         rd_t(8'h20, 32'(idx * 8 + lvl));
         rd_t(8'h00, (32'h1 << idx) | (idx == 24 ? 32'h20 : 32'h0));
         if (idx < 24)
            ack(lvl, {1'b0, 3'h2, 5'(idx)});
         else
            ack(lvl, {1'b0, 5'h15, 3'(idx - 23)});
         rd_t(8'h00, (32'h1 << idx) | (idx == 24 ? 32'h20 : 32'h0));
         if (idx >= 24)
            flip(idx - 24);
         wr_t(8'h00, (32'h1 << idx) | 32'h20);
         rd_t(8'h00, 32'h0);
      end
      // Short power-fail dip must be filtered out, long one latched
      wr_t(8'h04, 32'h1);
      for (n = 0; n < 2; n++)
      begin
         flip(21);
         repeat (n ? 120 : 50) @(posedge clk);
         flip(21);
         repeat (3) @(posedge clk);
         rd_t(8'h00, 32'(n));
      end
      repeat (3) @(posedge clk);
      check(32'(ack_q.size() + rd_q.size()), 32'h0);
      complete_run();
   end
endmodule : tb_lih_top

bind lih_top lih_checker u_chk (.i_clk, .i_rst, .i_rd, .o_rdata, .i_iack_req, .o_iack,
   .o_vme_iack, .i_vme_iack_done, .i_vme_iack_vector);

`default_nettype wire
